// ---- verilog/csb_defines.vh ----
`ifndef CSB_DEFINES_VH
`define CSB_DEFINES_VH
// register indices (word address = index, read over the plain port)
`define CSB_OFS_ERR_STATE 16'h1A02
`define CSB_OFS_ERR_CODE 16'h1A03
`define CSB_OFS_SUMMARY 16'h1A06
`define CSB_OFS_TORQUE_OFF 16'h1A10
`define CSB_OFS_STOP_FLAG 16'h1A11
`define CSB_OFS_ERR_FLAG 16'h1A1D
`define CSB_OFS_ACK_FLAG 16'h1A1E
`define CSB_OFS_OUT_SEL 16'h47A8
`define CSB_OFS_RAMP_TIME 16'h47E7
// summary word bit positions
`define CSB_SUM_TORQUE_OFF 0
`define CSB_SUM_STOP 1
`define CSB_SUM_ERROR 13
`define CSB_SUM_ACK 14
// fieldbus status word bit positions
`define CSB_P1_TORQUE_OFF 0
`define CSB_P1_STOP 1
`define CSB_P2_TORQUE_OFF 0
`define CSB_P2_STOP 12
// safe output selector code for the stop flag
`define CSB_OUT_SEL_STOP 8'h02
// reset values
`define CSB_OUT_SEL_RST 8'h00
`define CSB_RAMP_RST 16'h01F4
// timing: ramp unit 1 ms at 20 MHz
`define CSB_CLK_HZ 20000000
`define CSB_UNIT_MS 1
`define CSB_CYC_PER_MS (`CSB_CLK_HZ / 1000 * `CSB_UNIT_MS)
`endif

// ---- verilog/csb_ms_tick.v ----
`timescale 1ns/1ps
`include "csb_defines.vh"
// free running millisecond strobe
module csb_ms_tick #(
  parameter CYC_PER_MS = `CSB_CYC_PER_MS
) (
  input wire clk,
  input wire rst,
  output reg tick_q
);
  reg [31:0] cnt_q; // cycle counter inside one ms
  // count cycles, pulse once per ms
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else if (cnt_q == CYC_PER_MS - 1)
    begin
      cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end
endmodule

// ---- verilog/csb_stop_seq.v ----
`timescale 1ns/1ps
`include "csb_defines.vh"
// stop flag plus ramp timer ending in torque removal
module csb_stop_seq (
  input wire clk,
  input wire rst,
  input wire ms_tick,
  input wire req_any,
  input wire [15:0] ramp_ms,
  output reg stop_q,
  output reg torque_off_q
);
  localparam ST_IDLE = 2'b00; // no request
  localparam ST_RAMP = 2'b01; // motor ramps down
  localparam ST_OFF = 2'b10; // torque removed
  reg [1:0] st_q;
  reg [15:0] ms_q; // elapsed ms of ramp
  // sequence: any source starts, all sources gone releases
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      ms_q <= 16'h0000;
      stop_q <= 1'b0;
      torque_off_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          ms_q <= 16'h0000;
          if (req_any)
          begin
            st_q <= ST_RAMP;
            stop_q <= 1'b1;
          end
        end
        ST_RAMP:
        begin
          if (!req_any)
          begin
            st_q <= ST_IDLE;
            stop_q <= 1'b0;
          end
          else if (ms_tick)
          begin
            // the strobe runs free, so the first ms is partial: wait one
            // strobe more than the ramp so the ramp is never cut short
            if (ms_q >= ramp_ms)
            begin
              st_q <= ST_OFF;
              torque_off_q <= 1'b1;
            end
            ms_q <= ms_q + 16'h0001;
          end
        end
        ST_OFF:
        begin
          // torque stays off until every request is gone
          if (!req_any)
          begin
            st_q <= ST_IDLE;
            stop_q <= 1'b0;
            torque_off_q <= 1'b0;
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
          stop_q <= 1'b0;
          torque_off_q <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ---- verilog/csb_status_bank.v ----
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "csb_defines.vh"
// How it works
// - torque-off flag, summary bit 0
// - stop flag follows stop function, bit 1
// - stop from app, fault, or fieldbus
// - error flag mirrors any error, bit 13
// - ack-required flag pending event, bit 14
// - error state readable as 8 bits
// - error code readable as 8 bits
// - profile one word bit 0 torque-off
// - profile one word bit 1 stop
// - profile two word bit 0 torque-off
// - profile two word bit 12 stop
// - selector 02h routes stop to output
// - torque-off after ramp time elapses
module csb_status_bank (
  input wire MCLK,
  input wire RST,
  input wire [15:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  input wire APP_STOP_REQ,
  input wire FAULT_STOP_REQ,
  input wire BUS_STOP_REQ,
  input wire ERR_PRESENT,
  input wire ACK_PENDING,
  input wire [7:0] ERR_STATE_IN,
  input wire [7:0] ERR_CODE_IN,
  output reg TORQUE_OFF,
  output reg STOP_ACTIVE,
  output reg [15:0] FIRST_SAFETY_STATUS_WORD,
  output reg [15:0] SECOND_SAFETY_STATUS_WORD,
  output reg SAFE_DOUT
);
  reg [7:0] out_sel_q; // safe output selector, software writable
  reg [15:0] ramp_q; // ramp time in ms, software writable
  reg err_q; // error-active flag
  reg ack_q; // acknowledge-required flag
  reg [7:0] err_state_q; // error state, registered each cycle
  reg [7:0] err_code_q; // error code, registered each cycle, zero without error
  reg [31:0] rdata_d; // read mux result
  wire ms_tick; // one pulse per ms
  wire stop_w; // stop flag from sequencer
  wire toff_w; // torque-off flag from sequencer
  wire req_any; // any stop source active
  wire [31:0] summary_w; // summary word image
  wire [15:0] fb1_w; // first fieldbus word image
  wire [15:0] fb2_w; // second fieldbus word image
  genvar g; // bit index of the word images

  // timing overview, counted in clock cycles:
  //   a stop source high at edge n starts the sequencer at edge n
  //   the pins and both fieldbus words follow at edge n + 1
  //   flags read over the port come straight from the sequencer, and
  //   the read data register shows a flag at the same edge as the pin
  //   dropping the last source clears both flags the same way
  //   torque-off waits one ms strobe more than the ramp setting;
  //   the strobe runs free, so this costs up to one ms of extra
  //   ramp but never shortens it
  //   error and acknowledge levels are registered once, and the
  //   summary word and the single flags read those same registers,
  //   so the two views never disagree with each other
  //   read data stand one cycle after the strobe, zero otherwise

  // any single source is enough; release needs all gone; sources are
  // plain levels, so a source that flickers low for one cycle while
  // the others are low really does end the stop
  assign req_any = APP_STOP_REQ | FAULT_STOP_REQ | BUS_STOP_REQ;

  // millisecond strobe for the ramp; free running and never
  // restarted, so a ramp always starts inside a partial millisecond
  csb_ms_tick u_tick (
    .clk(MCLK),
    .rst(RST),
    .tick_q(ms_tick)
  );

  // the sequencer owns both safety flags; everything below only
  // copies them, so no second path can set or clear a flag on its
  // own and the pins cannot drift apart from the register view
  csb_stop_seq u_seq (
    .clk(MCLK),
    .rst(RST),
    .ms_tick(ms_tick),
    .req_any(req_any),
    .ramp_ms(ramp_q),
    .stop_q(stop_w),
    .torque_off_q(toff_w)
  );

  // summary word built from the live flags; spare bits stay zero
  // because they belong to functions that this block does not hold
  function [31:0] pack_summary;
    input toff;
    input stop;
    input err;
    input ack;
    begin
      pack_summary = 32'h0000_0000;
      pack_summary[`CSB_SUM_TORQUE_OFF] = toff;
      pack_summary[`CSB_SUM_STOP] = stop;
      pack_summary[`CSB_SUM_ERROR] = err;
      pack_summary[`CSB_SUM_ACK] = ack;
    end
  endfunction

  assign summary_w = pack_summary(toff_w, stop_w, err_q, ack_q);

  // status capture; levels follow their sources each cycle
  // no latching here: a flag that software must see after the
  // source is gone has to be held upstream, not in this bank
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      err_q <= 1'b0;
      ack_q <= 1'b0;
      err_state_q <= 8'h00;
      err_code_q <= 8'h00;
    end
    else
    begin
      err_q <= ERR_PRESENT;
      ack_q <= ACK_PENDING;
      err_state_q <= ERR_STATE_IN;
      // code only meaningful while an error stands
      if (ERR_PRESENT)
      begin
        err_code_q <= ERR_CODE_IN;
      end
      else
      begin
        err_code_q <= 8'h00;
      end
    end
  end

  // only two configuration words are writable; a write to any
  // status index is dropped silently, because status is owned by
  // hardware and software must never be able to fake a flag
  // config writes; status addresses have no write path
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      out_sel_q <= `CSB_OUT_SEL_RST;
      ramp_q <= `CSB_RAMP_RST;
    end
    else if (WR)
    begin
      case (ADDR)
        `CSB_OFS_OUT_SEL:
        begin
          out_sel_q <= WDATA[7:0];
        end
        `CSB_OFS_RAMP_TIME:
        begin
          ramp_q <= WDATA[15:0];
        end
        default:
        begin
          // status and unmapped: write dropped
          out_sel_q <= out_sel_q;
        end
      endcase
    end
  end

  // read map, every index one word:
  //   error state and error code: eight bits, upper bits zero
  //   summary word: torque-off, stop, error and acknowledge bits
  //   single flags: one bit each, in bit 0
  //   selector and ramp time: the two writable words
  //   anything else reads zero, so probing never sees stale data
  // the decode is purely combinational; the read data register
  // below adds the one cycle of latency the port promises, and the
  // address only has to stand in the strobe cycle itself
  // read decode
  always @*
  begin
    rdata_d = 32'h0000_0000;
    case (ADDR)
      `CSB_OFS_ERR_STATE:
      begin
        rdata_d = {24'h000000, err_state_q};
      end
      `CSB_OFS_ERR_CODE:
      begin
        rdata_d = {24'h000000, err_code_q};
      end
      `CSB_OFS_SUMMARY:
      begin
        rdata_d = summary_w;
      end
      `CSB_OFS_TORQUE_OFF:
      begin
        rdata_d = {31'h0000_0000, toff_w};
      end
      `CSB_OFS_STOP_FLAG:
      begin
        rdata_d = {31'h0000_0000, stop_w};
      end
      `CSB_OFS_ERR_FLAG:
      begin
        rdata_d = {31'h0000_0000, err_q};
      end
      `CSB_OFS_ACK_FLAG:
      begin
        rdata_d = {31'h0000_0000, ack_q};
      end
      `CSB_OFS_OUT_SEL:
      begin
        rdata_d = {24'h000000, out_sel_q};
      end
      `CSB_OFS_RAMP_TIME:
      begin
        rdata_d = {16'h0000, ramp_q};
      end
      default:
      begin
        // unmapped reads zero
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  // zero between reads, so a stale word never looks like a fresh one
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      RDATA <= 32'h0000_0000;
    end
    else if (RD)
    begin
      RDATA <= rdata_d;
    end
    else
    begin
      RDATA <= 32'h0000_0000;
    end
  end

  // one bit of a fieldbus word: torque-off, stop, or a spare zero
  // shared by both profiles, which differ only in the positions
  function place_bit;
    input integer pos;
    input integer toff_pos;
    input integer stop_pos;
    input toff;
    input stop;
    begin
      // spare positions belong to other functions and read low
      place_bit = 1'b0;
      if (pos == toff_pos)
      begin
        place_bit = toff;
      end
      else if (pos == stop_pos)
      begin
        place_bit = stop;
      end
    end
  endfunction

  // both profile words built bit by bit from the same two flags
  // so a position change stays a one-line edit of the defines
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_fb_bits
      // profile one: both flags side by side at the bottom
      assign fb1_w[g] = place_bit(g, `CSB_P1_TORQUE_OFF, `CSB_P1_STOP,
        toff_w, stop_w);
      // profile two: stop flag sits far up, the gap stays low
      assign fb2_w[g] = place_bit(g, `CSB_P2_TORQUE_OFF, `CSB_P2_STOP,
        toff_w, stop_w);
    end
  endgenerate

  // pin flags, one register stage after the sequencer, so the
  // pins are glitch free whatever the sequencer does in between
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      TORQUE_OFF <= 1'b0;
      STOP_ACTIVE <= 1'b0;
    end
    else
    begin
      TORQUE_OFF <= toff_w;
      STOP_ACTIVE <= stop_w;
    end
  end

  // profile one word, in the same stage as the pin flags
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      FIRST_SAFETY_STATUS_WORD <= 16'h0000;
    end
    else
    begin
      FIRST_SAFETY_STATUS_WORD <= fb1_w;
    end
  end

  // profile two word, same stage, so no profile runs ahead
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      SECOND_SAFETY_STATUS_WORD <= 16'h0000;
    end
    else
    begin
      SECOND_SAFETY_STATUS_WORD <= fb2_w;
    end
  end

  // safe output: only the stop selector code routes the flag
  // a selector change takes effect on the next edge, mid-stop too
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      SAFE_DOUT <= 1'b0;
    end
    else if (out_sel_q == `CSB_OUT_SEL_STOP)
    begin
      SAFE_DOUT <= stop_w;
    end
    else
    begin
      // other codes select functions not built here: held low
      SAFE_DOUT <= 1'b0;
    end
  end
endmodule

// ---- bench/csb_props.sv ----
`timescale 1ns/1ps
// passive watcher on the bank ports
module csb_props (
  input wire MCLK,
  input wire RST,
  input wire [15:0] ADDR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire APP_STOP_REQ,
  input wire FAULT_STOP_REQ,
  input wire BUS_STOP_REQ,
  input wire ERR_PRESENT,
  input wire TORQUE_OFF,
  input wire STOP_ACTIVE,
  input wire [15:0] FIRST_SAFETY_STATUS_WORD,
  input wire [15:0] SECOND_SAFETY_STATUS_WORD,
  input wire SAFE_DOUT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // any stop source
  wire req = APP_STOP_REQ | FAULT_STOP_REQ | BUS_STOP_REQ;
  AST_P1:
    assert property (FIRST_SAFETY_STATUS_WORD == {14'h0000, STOP_ACTIVE,
      TORQUE_OFF}) else $error("first word wrong");
  AST_P2:
    assert property (SECOND_SAFETY_STATUS_WORD[0] == TORQUE_OFF &&
      SECOND_SAFETY_STATUS_WORD[12] == STOP_ACTIVE) else $error("second word");
  AST_STOP_SET:
    assert property (req [*2] |=> STOP_ACTIVE) else $error("stop late");
  AST_STOP_CLR:
    assert property (!req [*2] |=> !STOP_ACTIVE) else $error("stop stuck");
  AST_TOFF:
    assert property ($rose(TORQUE_OFF) |-> $past(STOP_ACTIVE))
      else $error("torque off without ramp");
  AST_TOFF_CLR:
    assert property (!STOP_ACTIVE |-> !TORQUE_OFF) else $error("torque off");
  AST_DOUT:
    assert property (SAFE_DOUT |-> STOP_ACTIVE) else $error("dout");
  AST_ERR:
    assert property (RD && ADDR == 16'h1A1D |=>
      RDATA == {31'h0, $past(ERR_PRESENT, 2)}) else $error("error flag");
  // main scenarios reached
  cover property ($rose(TORQUE_OFF));
  cover property (SAFE_DOUT);
  cover property (RD && ADDR == 16'h1A1D && ERR_PRESENT);
endmodule
bind csb_status_bank csb_props i_csb_props (.MCLK(MCLK), .RST(RST),
  .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .APP_STOP_REQ(APP_STOP_REQ),
  .FAULT_STOP_REQ(FAULT_STOP_REQ), .BUS_STOP_REQ(BUS_STOP_REQ),
  .ERR_PRESENT(ERR_PRESENT), .TORQUE_OFF(TORQUE_OFF),
  .STOP_ACTIVE(STOP_ACTIVE),
  .FIRST_SAFETY_STATUS_WORD(FIRST_SAFETY_STATUS_WORD),
  .SECOND_SAFETY_STATUS_WORD(SECOND_SAFETY_STATUS_WORD),
  .SAFE_DOUT(SAFE_DOUT));

// ---- bench/csb_plc_model.sv ----
`timescale 1ns/1ps
// fieldbus controller: stop demand and status seen one frame late
module csb_plc_model (
  input wire clk,
  input wire demand,
  input wire [15:0] status_word,
  output reg stop_req_q,
  output reg seen_stop_q
);
  initial stop_req_q = 1'b0;
  // one cycle frame latency each way
  always @(posedge clk)
  begin
    stop_req_q <= demand;
    seen_stop_q <= status_word[12];
  end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`include "csb_defines.vh"
module tb_top;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [15:0] addr = 16'h0000;
  reg [31:0] wdata = 32'h00000000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg app = 1'b0;
  reg flt = 1'b0;
  reg dem = 1'b0;
  reg err = 1'b0;
  reg ack = 1'b0;
  reg [7:0] st = 8'h00;
  reg [7:0] cd = 8'h00;
  reg rd_d = 1'b0;
  reg [31:0] expq [$];
  wire breq, toff, stop, dout, seen;
  wire [31:0] rdata;
  wire [15:0] w1, w2;
  integer errors = 0, tests_run = 0, i, n, r;
  always #25 mclk = ~mclk;
  csb_status_bank i_csb_status_bank (.MCLK(mclk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .APP_STOP_REQ(app),
    .FAULT_STOP_REQ(flt), .BUS_STOP_REQ(breq), .ERR_PRESENT(err),
    .ACK_PENDING(ack), .ERR_STATE_IN(st), .ERR_CODE_IN(cd),
    .TORQUE_OFF(toff), .STOP_ACTIVE(stop), .FIRST_SAFETY_STATUS_WORD(w1),
    .SECOND_SAFETY_STATUS_WORD(w2), .SAFE_DOUT(dout));
  csb_plc_model i_csb_plc_model (.clk(mclk), .demand(dem),
    .status_word(w2), .stop_req_q(breq), .seen_stop_q(seen));
  task chk(input [31:0] got, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task summarize;
  begin
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task wr_reg(input [15:0] a, input [31:0] d);
  begin
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  end
  endtask
  // expectation noted now, compared by the read check below
  task rd_reg(input [15:0] a, input [31:0] e);
  begin
    expq.push_back(e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
  end
  endtask
  // read data valid only in the cycle after the strobe
  always @(posedge mclk)
  begin
    rd_d <= rd;
    if (rd_d)
      chk(rdata, expq.pop_front());
  end
  // cut a hang well past the longest ramp
  initial
  begin
    #4000000;
    errors = errors + 1;
    summarize;
  end
  initial
  begin
    r = $urandom(15532);
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(16'h47A8, 32'h00000000);
    rd_reg(16'h47E7, 32'h000001F4);
    rd_reg(16'h1A04, 32'h00000000);
    rd_reg(16'h1A03, 32'h00000000);
    wr_reg(16'h1A06, $urandom);
    wr_reg(16'h1A10, 32'hFFFFFFFF);
    rd_reg(16'h1A06, 32'h00000000);
    rd_reg(16'h1A10, 32'h00000000);
    st <= $urandom;
    cd <= $urandom;
    err <= 1'b1;
    ack <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_reg(16'h1A02, {24'h000000, st});
    rd_reg(16'h1A03, {24'h000000, cd});
    rd_reg(16'h1A1D, 32'h00000001);
    rd_reg(16'h1A1E, 32'h00000001);
    rd_reg(16'h1A06, 32'h00006000);
    err <= 1'b0;
    ack <= 1'b0;
    repeat (3) @(posedge mclk);
    rd_reg(16'h1A06, 32'h00000000);
    wr_reg(16'h47E7, 32'h00000002);
    // each stop source in turn; selector off for the last
    for (i = 0; i < 3; i = i + 1)
    begin
      wr_reg(16'h47A8, (i == 2) ? 32'h00000000 : 32'h00000002);
      @(posedge mclk);
      app <= (i == 0);
      flt <= (i == 1);
      dem <= (i == 2);
      repeat (5) @(posedge mclk);
      #1;
      chk(stop, 1);
      chk(dout, i != 2);
      rd_reg(16'h1A11, 32'h00000001);
      chk(seen, 1);
      if (i == 0)
      begin
        // 2 ms ramp: torque-off no earlier than 2 ms after the stop
        n = 0;
        while (toff !== 1'b1 && n < 3 * `CSB_CYC_PER_MS + 50)
        begin
          @(posedge mclk);
          n = n + 1;
        end
        r = (n + 10 >= 2 * `CSB_CYC_PER_MS) && (n <= 3 * `CSB_CYC_PER_MS);
        chk(r, 1);
        rd_reg(16'h1A06, 32'h00000003);
        rd_reg(16'h1A10, 32'h00000001);
      end
      app <= 1'b0;
      flt <= 1'b0;
      dem <= 1'b0;
      repeat (5) @(posedge mclk);
      #1;
      chk({toff, stop, dout}, 0);
    end
    repeat (3) @(posedge mclk);
    summarize;
  end
endmodule
